// ==== design/vicf_defs.svh ====
// Register offsets, field positions and reset values of the
// controller setup and state registers.
// Assumes word offsets on the register access port.
`ifndef VICF_DEFS_SVH
`define VICF_DEFS_SVH

`define VICF_ADDR_W 6
`define VICF_SETUP_OFS 6'h28
`define VICF_STATE_OFS 6'h29
`define VICF_VSIZE_LSB 0
`define VICF_VSIZE_MSB 2
`define VICF_CHAIN_BIT 3
`define VICF_SETUP_MSB 3
`define VICF_SETUP_RST 4'h0
`define VICF_NUM_MSB 5
`define VICF_NUM_TOP_BIT 5
`define VICF_WAIT_BIT 31
`define VICF_CHAIN_NUM 6'h20
`define VICF_LVL_W 6
`define VICF_MAX_SRC 32
`define VICF_ENTRY_MIN 10'h004
`define VICF_ENTRY_W 10

`endif

// ==== design/vicf_pkg.sv ====
// Shared types of the vectored interrupt controller setup/state block.
// Assumes the constants header is included by each user.
package vicf_pkg;
  typedef logic [5:0] vicf_num_type;
  typedef logic [5:0] vicf_lvl_type;
  typedef logic [2:0] vicf_vsize_type;
  typedef logic [31:0] vicf_word_type;
endpackage

// ==== design/vicf_if.sv ====
// Carrier between the setup register, the priority resolver and the top.
// Assumes all three sit in one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface vicf_if;
  import vicf_pkg::*;
  vicf_vsize_type vec_size;
  logic chain_on;
  vicf_num_type top_num;
  vicf_lvl_type top_lvl;
  logic top_valid;
  modport setup (output vec_size, output chain_on);
  modport prio (input chain_on, output top_num, output top_lvl, output top_valid);
  modport core (input vec_size, input chain_on, input top_num, input top_lvl, input top_valid);
endinterface
`default_nettype wire

// ==== design/vicf_setup.sv ====
// Controller setup register: entry size code and chain input enable.
// Assumes the top decodes the write strobe for the setup offset.
`timescale 1ns/1ps
`default_nettype none
`include "vicf_defs.svh"
module vicf_setup import vicf_pkg::*; #(
  parameter bit CHAIN_EN = 1'b1
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic wr_i,
  input wire logic [`VICF_SETUP_MSB:0] wdata_i,
  vicf_if.setup cfg
);
  logic [`VICF_SETUP_MSB:0] setup_ff;
  logic [`VICF_SETUP_MSB:0] nxt_setup;

  always_comb begin
    nxt_setup = setup_ff;
    if (wr_i) begin
      nxt_setup[`VICF_VSIZE_MSB:`VICF_VSIZE_LSB] = wdata_i[`VICF_VSIZE_MSB:`VICF_VSIZE_LSB];
      nxt_setup[`VICF_CHAIN_BIT] = wdata_i[`VICF_CHAIN_BIT] & CHAIN_EN;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      setup_ff <= `VICF_SETUP_RST;
    end else begin
      setup_ff <= nxt_setup;
    end
  end

  assign cfg.vec_size = setup_ff[`VICF_VSIZE_MSB:`VICF_VSIZE_LSB];
  assign cfg.chain_on = setup_ff[`VICF_CHAIN_BIT];
endmodule
`default_nettype wire

// ==== design/vicf_prio.sv ====
// Priority resolver: picks the active source with the highest level.
// Assumes source pending bits and levels come from neighbouring logic.
`timescale 1ns/1ps
`default_nettype none
`include "vicf_defs.svh"
module vicf_prio import vicf_pkg::*; #(
  parameter int NUM_IRQ = 32,
  parameter int RIL_W = 6,
  parameter bit CHAIN_EN = 1'b1
) (
  input wire logic [`VICF_MAX_SRC-1:0] act_i,
  input wire logic [`VICF_MAX_SRC*`VICF_LVL_W-1:0] lvl_i,
  input wire logic chain_req_i,
  input wire logic [`VICF_LVL_W-1:0] chain_lvl_i,
  vicf_if.prio res
);
  localparam logic [`VICF_LVL_W:0] LVL_SPAN = 7'h01 << RIL_W;
  localparam vicf_lvl_type LVL_MASK = 6'(LVL_SPAN - 7'h01);

  vicf_lvl_type best_lvl [0:`VICF_MAX_SRC];
  vicf_num_type best_num [0:`VICF_MAX_SRC];
  logic best_val [0:`VICF_MAX_SRC];
  vicf_lvl_type chain_lvl;
  logic chain_take;

  assign best_lvl[0] = '0;
  assign best_num[0] = '0;
  assign best_val[0] = 1'b0;

  // Strict compare keeps the lower number on a tie
  genvar i;
  generate
    for (i = 0; i < `VICF_MAX_SRC; i++) begin : g_src
      vicf_lvl_type lv;
      logic take;
      assign lv = lvl_i[i*`VICF_LVL_W +: `VICF_LVL_W] & LVL_MASK;
      assign take = act_i[i] && (i < NUM_IRQ) && (!best_val[i] || lv > best_lvl[i]);
      assign best_lvl[i+1] = take ? lv : best_lvl[i];
      assign best_num[i+1] = take ? 6'(i) : best_num[i];
      assign best_val[i+1] = best_val[i] | take;
    end
  endgenerate

  assign chain_lvl = chain_lvl_i & LVL_MASK;
  assign chain_take = CHAIN_EN && res.chain_on && chain_req_i &&
                      (!best_val[`VICF_MAX_SRC] || chain_lvl > best_lvl[`VICF_MAX_SRC]);

  assign res.top_num = chain_take ? `VICF_CHAIN_NUM : best_num[`VICF_MAX_SRC];
  assign res.top_lvl = chain_take ? chain_lvl : best_lvl[`VICF_MAX_SRC];
  assign res.top_valid = chain_take | best_val[`VICF_MAX_SRC];
endmodule
`default_nettype wire

// ==== design/vicf_top.sv ====
// Setup and state registers of a vectored interrupt controller, with its
// request output toward a processor or a downstream chain input.
// Assumes one clock, word offsets on the register port, and neighbouring
// logic that supplies per-source pending bits and levels.
`timescale 1ns/1ps
`default_nettype none
`include "vicf_defs.svh"
module vicf_top import vicf_pkg::*; #(
  parameter int NUM_IRQ = 32,
  parameter int RIL_W = 6,
  parameter bit CHAIN_EN = 1'b1,
  // Arbitrary default; the system sets a unique value
  parameter logic [7:0] CTRL_ID = 8'h00
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [`VICF_ADDR_W-1:0] csr_addr_i,
  input wire logic csr_read_i,
  input wire logic csr_write_i,
  input wire logic [31:0] csr_wdata_i,
  output logic [31:0] csr_rdata_o,
  input wire logic [`VICF_MAX_SRC-1:0] src_active_i,
  input wire logic [`VICF_MAX_SRC*`VICF_LVL_W-1:0] src_level_i,
  input wire logic chain_req_i,
  input wire logic [`VICF_LVL_W-1:0] chain_level_i,
  output logic ext_req_o,
  output logic [`VICF_LVL_W-1:0] ext_level_o,
  output logic [`VICF_NUM_MSB:0] ext_number_o,
  output logic [`VICF_ENTRY_W-1:0] vec_bytes_o,
  output logic [7:0] ctrl_id_o,
  output logic [31:0] mst_address_o,
  output logic mst_read_o,
  output logic mst_write_o,
  output logic [31:0] mst_wdata_o
);
  vicf_if res ();

  logic setup_wr;
  vicf_word_type setup_word;
  vicf_word_type state_word;
  vicf_word_type rdata_ff;
  vicf_word_type nxt_rdata;
  logic req_ff;
  logic nxt_req;
  vicf_lvl_type lvl_ff;
  vicf_lvl_type nxt_lvl;
  vicf_num_type num_ff;
  vicf_num_type nxt_num;
  logic [`VICF_ENTRY_W-1:0] vbytes_ff;
  logic [`VICF_ENTRY_W-1:0] nxt_vbytes;
  // Masks mirror the build-time source count and level width
  localparam logic [`VICF_MAX_SRC:0] SRC_SPAN = 33'h1 << NUM_IRQ;
  localparam logic [`VICF_MAX_SRC-1:0] SRC_MASK = 32'(SRC_SPAN - 33'h1);
  localparam logic [`VICF_LVL_W:0] LVL_SPAN = 7'h01 << RIL_W;
  localparam vicf_lvl_type LVL_MASK = 6'(LVL_SPAN - 7'h01);
  // Only for the checks below; sources past the count are not live
  logic [`VICF_MAX_SRC-1:0] src_live;

  assign setup_wr = csr_write_i && (csr_addr_i == `VICF_SETUP_OFS);

  vicf_setup #(
    .CHAIN_EN(CHAIN_EN)
  ) u_setup (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .wr_i(setup_wr),
    .wdata_i(csr_wdata_i[`VICF_SETUP_MSB:0]),
    .cfg(res.setup)
  );

  vicf_prio #(
    .NUM_IRQ(NUM_IRQ),
    .RIL_W(RIL_W),
    .CHAIN_EN(CHAIN_EN)
  ) u_prio (
    .act_i(src_active_i),
    .lvl_i(src_level_i),
    .chain_req_i(chain_req_i),
    .chain_lvl_i(chain_level_i),
    .res(res.prio)
  );

  always_comb begin
    setup_word = '0;
    setup_word[`VICF_VSIZE_MSB:`VICF_VSIZE_LSB] = res.vec_size;
    setup_word[`VICF_CHAIN_BIT] = res.chain_on;
    state_word = '0;
    if (res.top_valid) begin
      state_word[`VICF_NUM_MSB:0] = res.top_num;
    end
    if (!CHAIN_EN) begin
      state_word[`VICF_NUM_TOP_BIT] = 1'b0;
    end
    state_word[`VICF_WAIT_BIT] = res.top_valid;
  end

  // Read data held until the next read, so slow masters may sample late
  always_comb begin
    nxt_rdata = rdata_ff;
    if (csr_read_i) begin
      case (csr_addr_i)
        `VICF_SETUP_OFS: nxt_rdata = setup_word;
        `VICF_STATE_OFS: nxt_rdata = state_word;
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_comb begin
    nxt_req = res.top_valid;
    nxt_lvl = res.top_valid ? res.top_lvl : '0;
    nxt_num = state_word[`VICF_NUM_MSB:0];
    nxt_vbytes = `VICF_ENTRY_MIN << res.vec_size;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rdata_ff <= '0;
      req_ff <= 1'b0;
      lvl_ff <= '0;
      num_ff <= '0;
      vbytes_ff <= `VICF_ENTRY_MIN;
    end else begin
      rdata_ff <= nxt_rdata;
      req_ff <= nxt_req;
      lvl_ff <= nxt_lvl;
      num_ff <= nxt_num;
      vbytes_ff <= nxt_vbytes;
    end
  end

  assign csr_rdata_o = rdata_ff;
  assign ext_req_o = req_ff;
  assign ext_level_o = lvl_ff;
  assign ext_number_o = num_ff;
  assign vec_bytes_o = vbytes_ff;
  assign ctrl_id_o = CTRL_ID;
  assign mst_address_o = '0;
  assign mst_read_o = 1'b0;
  assign mst_write_o = 1'b0;
  assign mst_wdata_o = '0;
  assign src_live = src_active_i & SRC_MASK;

  property p_vsize_store;
    @(posedge clk_i) disable iff (!rstn_i)
    setup_wr ##1 1'b1 |-> res.vec_size == $past(csr_wdata_i[`VICF_VSIZE_MSB:`VICF_VSIZE_LSB]);
  endproperty
  a_vsize_store: assert property (p_vsize_store) else $error("entry size not stored");

  property p_vbytes;
    @(posedge clk_i) disable iff (!rstn_i)
    setup_wr ##2 1'b1 |-> vec_bytes_o == (`VICF_ENTRY_MIN << $past(csr_wdata_i[2:0], 2));
  endproperty
  a_vbytes: assert property (p_vbytes) else $error("entry bytes wrong");

  property p_chain_write;
    @(posedge clk_i) disable iff (!rstn_i)
    setup_wr |=> res.chain_on == ($past(csr_wdata_i[`VICF_CHAIN_BIT]) && CHAIN_EN);
  endproperty
  a_chain_write: assert property (p_chain_write) else $error("chain enable wrong");

  property p_setup_read;
    @(posedge clk_i) disable iff (!rstn_i)
    setup_wr ##1 !csr_write_i ##1
      (csr_read_i && csr_addr_i == `VICF_SETUP_OFS && !csr_write_i) |=>
      csr_rdata_o == {28'h0000000, $past(csr_wdata_i[3], 3) & CHAIN_EN,
                      $past(csr_wdata_i[2:0], 3)};
  endproperty
  a_setup_read: assert property (p_setup_read) else $error("setup readback wrong");

  property p_reserved_zero;
    @(posedge clk_i) disable iff (!rstn_i)
    csr_read_i && csr_addr_i == `VICF_SETUP_OFS |=> csr_rdata_o[31:4] == 28'h0000000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_state_read;
    @(posedge clk_i) disable iff (!rstn_i)
    csr_read_i && csr_addr_i == `VICF_STATE_OFS |=>
      csr_rdata_o[31] == $past(res.top_valid) && csr_rdata_o[30:6] == '0;
  endproperty
  a_state_read: assert property (p_state_read) else $error("waiting flag wrong");

  property p_empty_zero;
    @(posedge clk_i) disable iff (!rstn_i)
    csr_read_i && csr_addr_i == `VICF_STATE_OFS && !res.top_valid |=> csr_rdata_o == '0;
  endproperty
  a_empty_zero: assert property (p_empty_zero) else $error("empty state not zero");

  property p_chain_num;
    @(posedge clk_i) disable iff (!rstn_i)
    res.top_valid && res.top_num == `VICF_CHAIN_NUM |->
      CHAIN_EN && res.chain_on && chain_req_i ##1 ext_number_o == `VICF_CHAIN_NUM;
  endproperty
  a_chain_num: assert property (p_chain_num) else $error("chain number wrong");

  property p_bit5;
    @(posedge clk_i) disable iff (!rstn_i)
    !CHAIN_EN |-> !csr_rdata_o[`VICF_NUM_TOP_BIT] && !ext_number_o[`VICF_NUM_TOP_BIT];
  endproperty
  a_bit5: assert property (p_bit5) else $error("bit 5 set without chain");

  property p_top_source;
    @(posedge clk_i) disable iff (!rstn_i)
    res.top_valid && res.top_num < `VICF_CHAIN_NUM |->
      src_active_i[res.top_num[4:0]] && res.top_num < NUM_IRQ;
  endproperty
  a_top_source: assert property (p_top_source) else $error("top source not active");

  property p_master_idle;
    @(posedge clk_i) disable iff (!rstn_i)
    !mst_read_o && !mst_write_o;
  endproperty
  a_master_idle: assert property (p_master_idle) else $error("master port active");

  property p_chain_off;
    @(posedge clk_i) disable iff (!rstn_i)
    !res.chain_on && chain_req_i |-> !(res.top_valid && res.top_num == `VICF_CHAIN_NUM);
  endproperty
  a_chain_off: assert property (p_chain_off) else $error("disabled chain won");

  property p_chain_win;
    @(posedge clk_i) disable iff (!rstn_i)
    CHAIN_EN && res.chain_on && chain_req_i && src_live == '0 |->
      res.top_valid && res.top_num == `VICF_CHAIN_NUM;
  endproperty
  a_chain_win: assert property (p_chain_win) else $error("lone chain request lost");

  property p_idle_none;
    @(posedge clk_i) disable iff (!rstn_i)
    src_live == '0 && !(res.chain_on && chain_req_i) |-> !res.top_valid;
  endproperty
  a_idle_none: assert property (p_idle_none) else $error("uncounted source won");

  property p_level_width;
    @(posedge clk_i) disable iff (!rstn_i)
    (ext_level_o & ~LVL_MASK) == '0;
  endproperty
  a_level_width: assert property (p_level_width) else $error("level wider than built");

  property p_req_follow;
    @(posedge clk_i) disable iff (!rstn_i)
    1'b1 |=> ext_req_o == $past(res.top_valid);
  endproperty
  a_req_follow: assert property (p_req_follow) else $error("request out lags");

  property p_stray_write;
    @(posedge clk_i) disable iff (!rstn_i)
    csr_write_i && csr_addr_i != `VICF_SETUP_OFS |=>
      $stable(res.vec_size) && $stable(res.chain_on);
  endproperty
  a_stray_write: assert property (p_stray_write) else $error("stray write landed");

  property p_unmapped_zero;
    @(posedge clk_i) disable iff (!rstn_i)
    csr_read_i && csr_addr_i != `VICF_SETUP_OFS && csr_addr_i != `VICF_STATE_OFS |=>
      csr_rdata_o == '0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero");

  property p_rdata_hold;
    @(posedge clk_i) disable iff (!rstn_i)
    !csr_read_i |=> $stable(csr_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  property p_reset_clear;
    @(posedge clk_i)
    !rstn_i |=> !ext_req_o && csr_rdata_o == '0 && vec_bytes_o == `VICF_ENTRY_MIN &&
      ext_number_o == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left state");

  // One check per source: nothing live outranks the reported level
  genvar k;
  generate
    for (k = 0; k < `VICF_MAX_SRC; k++) begin : g_rank
      property p_no_higher;
        @(posedge clk_i) disable iff (!rstn_i)
        src_live[k] |-> res.top_valid &&
          (src_level_i[k*`VICF_LVL_W +: `VICF_LVL_W] & LVL_MASK) <= res.top_lvl;
      endproperty
      a_no_higher: assert property (p_no_higher) else $error("higher source lost");
    end
  endgenerate
endmodule
`default_nettype wire

// ==== verif/vicf_proc_model.sv ====
// Processor external interrupt port model: latches the offered request.
// Assumes a registered request output in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module vicf_proc_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic req_i,
  input wire logic [5:0] level_i,
  input wire logic [5:0] number_i,
  output logic seen_req_o,
  output logic [5:0] seen_level_o,
  output logic [5:0] seen_number_o
);
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      seen_req_o <= 1'h0;
      seen_level_o <= 6'h00;
      seen_number_o <= 6'h00;
    end else begin
      seen_req_o <= req_i;
      seen_level_o <= level_i;
      seen_number_o <= number_i;
    end
  end
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench: setup/state registers and request output.
// Assumes design files and the port model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "vicf_defs.svh"
module tb_top;
  typedef struct packed {
    logic ea;
    logic [4:0] a;
    logic [5:0] la;
    logic eb;
    logic [4:0] b;
    logic [5:0] lb;
    logic ch;
    logic [5:0] lc;
    logic req;
    logic [5:0] num;
    logic [5:0] lvl;
  } vicf_row_type;
  logic clk;
  logic rst_n;
  logic [5:0] addr;
  logic rd_en;
  logic wr_en;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] rdata2;
  logic [31:0] act;
  logic [`VICF_MAX_SRC*`VICF_LVL_W-1:0] lv;
  logic ch;
  logic [5:0] chl;
  logic req;
  logic [5:0] lvl;
  logic [5:0] num;
  logic [5:0] num2;
  logic [9:0] vbytes;
  logic [7:0] cid;
  logic [31:0] maddr;
  logic [31:0] mwd;
  logic mrd;
  logic mwr;
  logic s_req;
  logic [5:0] s_lvl;
  logic [5:0] s_num;
  int n_fail;
  int checked;
  vicf_row_type rows [8];

  // Controller number is arbitrary
  vicf_top #(.CTRL_ID(8'h5a)) uut (
    .clk_i(clk), .rstn_i(rst_n), .csr_addr_i(addr), .csr_read_i(rd_en),
    .csr_write_i(wr_en), .csr_wdata_i(wdata), .csr_rdata_o(rdata),
    .src_active_i(act), .src_level_i(lv), .chain_req_i(ch), .chain_level_i(chl),
    .ext_req_o(req), .ext_level_o(lvl), .ext_number_o(num), .vec_bytes_o(vbytes),
    .ctrl_id_o(cid), .mst_address_o(maddr), .mst_read_o(mrd), .mst_write_o(mwr),
    .mst_wdata_o(mwd));
  // Small build without chain input
  // not cascaded with uut
  vicf_top #(.NUM_IRQ(8), .RIL_W(3), .CHAIN_EN(1'b0)) uut_nc (
    .clk_i(clk), .rstn_i(rst_n), .csr_addr_i(addr), .csr_read_i(rd_en),
    .csr_write_i(wr_en), .csr_wdata_i(wdata), .csr_rdata_o(rdata2),
    .src_active_i(act), .src_level_i(lv), .chain_req_i(ch), .chain_level_i(chl),
    .ext_req_o(), .ext_level_o(), .ext_number_o(num2), .vec_bytes_o(),
    .ctrl_id_o(), .mst_address_o(), .mst_read_o(), .mst_write_o(), .mst_wdata_o());
  vicf_proc_model host (.clk_i(clk), .rstn_i(rst_n), .req_i(req), .level_i(lvl),
    .number_i(num), .seen_req_o(s_req), .seen_level_o(s_lvl), .seen_number_o(s_num));

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_en = 1'h1;
    @(negedge clk);
    wr_en = 1'h0;
  endtask

  // Read data is registered, so it is looked at one edge later
  task automatic rd(input logic [5:0] a);
    @(negedge clk);
    addr = a;
    rd_en = 1'h1;
    @(negedge clk);
    rd_en = 1'h0;
  endtask

  task automatic drive(input vicf_row_type r);
    @(negedge clk);
    act = '0;
    lv = '0;
    if (r.ea) begin
      act[r.a] = 1'h1;
      lv[r.a*6 +: 6] = r.la;
    end
    if (r.eb) begin
      act[r.b] = 1'h1;
      lv[r.b*6 +: 6] = r.lb;
    end
    ch = r.ch;
    chl = r.lc;
  endtask

  task automatic stop_test;
    $display("counts: checked=%0d failed=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Whole run needs about a hundred cycles
  initial begin
    #80000;
    n_fail++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    rst_n = 1'h0;
    addr = 6'h00;
    rd_en = 1'h0;
    wr_en = 1'h0;
    wdata = 32'h0;
    act = 32'h0;
    lv = '0;
    ch = 1'h0;
    chl = 6'h00;
    rows = '{
      '{1'h0,5'h00,6'h00,1'h0,5'h00,6'h00,1'h0,6'h00,1'h0,6'h00,6'h00},
      '{1'h1,5'h03,6'h05,1'h0,5'h00,6'h00,1'h0,6'h00,1'h1,6'h03,6'h05},
      '{1'h1,5'h03,6'h05,1'h1,5'h0a,6'h09,1'h0,6'h00,1'h1,6'h0a,6'h09},
      '{1'h1,5'h07,6'h04,1'h1,5'h02,6'h04,1'h0,6'h00,1'h1,6'h02,6'h04},
      '{1'h1,5'h1f,6'h13,1'h0,5'h00,6'h00,1'h1,6'h14,1'h1,6'h20,6'h14},
      '{1'h1,5'h1f,6'h13,1'h0,5'h00,6'h00,1'h1,6'h13,1'h1,6'h1f,6'h13},
      '{1'h1,5'h00,6'h00,1'h0,5'h00,6'h00,1'h0,6'h00,1'h1,6'h00,6'h00},
      '{1'h1,5'h1f,6'h3f,1'h1,5'h1e,6'h3e,1'h1,6'h3e,1'h1,6'h1f,6'h3f}};
    repeat (8) @(negedge clk);
    rst_n = 1'h1;
    rd(`VICF_SETUP_OFS);
    chk(rdata, 32'h0, "setup reset");
    chk({22'h0, vbytes}, 32'h4, "entry bytes reset");
    chk({24'h0, cid}, 32'h5a, "controller number");
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wr(`VICF_SETUP_OFS, 32'(i));
      rd(`VICF_SETUP_OFS);
      chk(rdata, 32'(i), "size code readback");
      chk({22'h0, vbytes}, 32'h4 << i, "entry bytes");
    end
    $display("test entry size done");
    wr(`VICF_SETUP_OFS, 32'hffff_fff8);
    rd(`VICF_SETUP_OFS);
    chk(rdata, 32'h8, "reserved bits");
    chk(rdata2, 32'h0, "chain detect absent");
    $display("test chain detect done");
    foreach (rows[i]) begin
      drive(rows[i]);
      rd(`VICF_STATE_OFS);
      chk({31'h0, s_req}, {31'h0, rows[i].req}, "request out");
      chk({26'h0, s_num}, {26'h0, rows[i].num}, "number out");
      chk({26'h0, s_lvl}, {26'h0, rows[i].lvl}, "level out");
      chk(rdata, {rows[i].req, 25'h0, rows[i].num}, "state word");
      chk({31'h0, num2[5]}, 32'h0, "number bit 5");
    end
    $display("test priority rows done");
    wr(`VICF_SETUP_OFS, 32'h0);
    drive('{1'h0,5'h00,6'h00,1'h0,5'h00,6'h00,1'h1,6'h3f,1'h0,6'h00,6'h00});
    rd(`VICF_STATE_OFS);
    chk(rdata, 32'h0, "chain disabled");
    wr(`VICF_STATE_OFS, 32'hffff_ffff);
    wr(6'h2a, 32'h7);
    rd(6'h2a);
    chk(rdata, 32'h0, "unmapped read");
    rd(`VICF_SETUP_OFS);
    chk(rdata, 32'h0, "stray writes ignored");
    chk({30'h0, mrd, mwr}, 32'h0, "master strobes idle");
    chk(maddr | mwd, 32'h0, "master bus idle");
    $display("test refusals done");
    drive('{1'h1,5'h01,6'h09,1'h1,5'h02,6'h02,1'h0,6'h00,1'h0,6'h00,6'h00});
    rd(`VICF_STATE_OFS);
    chk({26'h0, s_num}, 32'h1, "wide level wins");
    chk({26'h0, num2}, 32'h2, "level width masked");
    drive('{1'h1,5'h09,6'h05,1'h1,5'h04,6'h01,1'h0,6'h00,1'h0,6'h00,6'h00});
    rd(`VICF_STATE_OFS);
    chk({26'h0, s_num}, 32'h9, "high source");
    chk(rdata2, 32'h8000_0004, "source count limit");
    $display("test build limits done");
    // Mid-run reset with the chain enabled and requesting alone
    wr(`VICF_SETUP_OFS, 32'hf);
    drive('{1'h0,5'h00,6'h00,1'h0,5'h00,6'h00,1'h1,6'h00,1'h1,6'h20,6'h00});
    rd(`VICF_STATE_OFS);
    chk(rdata, 32'h8000_0020, "chain alone");
    rst_n = 1'h0;
    repeat (2) @(negedge clk);
    chk({22'h0, vbytes}, 32'h4, "entry bytes in reset");
    chk({31'h0, req}, 32'h0, "request in reset");
    rst_n = 1'h1;
    rd(`VICF_SETUP_OFS);
    chk(rdata, 32'h0, "setup after reset");
    chk({31'h0, s_req}, 32'h0, "chain off after reset");
    $display("test mid-run reset done");
    stop_test();
  end
endmodule
`default_nettype wire
